// *** verilog/jbdpll_pkg.sv ***
// constants shared by the jitter-bounded digital pll
// assumes one system clock; no software registers
package jbdpll_pkg;
	localparam int ACC_W_DEF = 4;
	localparam int PHASE_N_DEF = 2;
	localparam int DIV_W_DEF = 8;
	localparam int PERR_W_DEF = 8;
	localparam logic [3:0] SAR_RST = 4'h1;
endpackage

// *** verilog/jbdpll_divider.sv ***
// loadable divide-by-n counter producing a one-cycle pulse
// assumes event input is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module jbdpll_divider #(
	parameter int W = 8
) (
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic         event_i,
	input  wire logic [W-1:0] factor_i,
	output logic              tick_o,
	output logic [W-1:0]      count_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} jbdpll_div_type;

	jbdpll_div_type st_reg;
	jbdpll_div_type st_next;

	initial begin
		if (W < 2) $error("divider width too small");
	end

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (event_i) begin
			if (st_reg.cnt + W'(1) >= factor_i) begin
				st_next.cnt = '0;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;
	assign count_o = st_reg.cnt;
endmodule
`default_nettype wire

// *** verilog/jbdpll_top.sv ***
// jitter-bounded digital pll: accumulator oscillator steered by an approximation register
// assumes ref_i is asynchronous; p and q are held steady by the controlling party
`timescale 1ns/1ps
`default_nettype none
module jbdpll_top
	import jbdpll_pkg::*;
#(
	parameter int ACC_W   = jbdpll_pkg::ACC_W_DEF,
	parameter int PHASE_N = jbdpll_pkg::PHASE_N_DEF,
	parameter int DIV_W   = jbdpll_pkg::DIV_W_DEF,
	parameter int PERR_W  = jbdpll_pkg::PERR_W_DEF
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             ref_i,
	input  wire logic [DIV_W-1:0] p_factor_i,
	input  wire logic [DIV_W-1:0] q_factor_i,
	output logic                  clk_out_o,
	output logic [ACC_W-1:0]      sar_o,
	output logic [PHASE_N-1:0]    phase_o,
	output logic                  locked_o
);
	import jbdpll_pkg::*;

	typedef struct packed {
		logic [2:0]         ref_sync;
		logic [ACC_W-1:0]   acc;
		logic [ACC_W-1:0]   sar;
		logic               out_d;
		logic [DIV_W-1:0]   pcount;
		logic [PHASE_N-1:0] phase;
		logic signed [PERR_W-1:0] perr;
		logic               locked;
	} jbdpll_state_type;

	jbdpll_state_type st_reg;
	jbdpll_state_type st_next;

	logic             ref_rise;
	logic             out_rise;
	logic             fq_tick;
	logic signed [PERR_W-1:0] perr_sum;
	logic signed [PERR_W-1:0] period_lim;
	logic               freq_equal;
	logic               freq_low;
	logic               freq_high;
	logic               perr_full_pos;
	logic               perr_full_neg;
	logic               sar_at_top;
	logic               sar_at_bottom;
	logic               step_up;
	logic               step_down;
	logic               sync_pulse;
	logic [ACC_W-1:0]   sar_stepped;
	logic [DIV_W-1:0]   pcount_stepped;
	logic [PHASE_N-1:0] phase_sampled;

	initial begin
		if (ACC_W != 4) $error("oscillator accumulator must be four bits");
		if (PHASE_N < 1 || PHASE_N > ACC_W) $error("phase width out of range");
		if (PERR_W <= ACC_W + 1) $error("phase error width too small");
	end

	assign ref_rise = st_reg.ref_sync[1] & ~st_reg.ref_sync[2];
	assign out_rise = st_reg.acc[ACC_W-1] & ~st_reg.out_d;
	assign period_lim = PERR_W'(1 << PHASE_N);
	assign phase_sampled = st_reg.acc[ACC_W-1 -: PHASE_N];

	// divided reference, fq
	jbdpll_divider #(.W(DIV_W)) u_qdiv (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n_i),
		.event_i  (ref_rise),
		.factor_i (q_factor_i),
		.tick_o   (fq_tick),
		.count_o  ()
	);

	// phase seen at reference edge, signed about mid-period
	always_comb begin
		perr_sum = st_reg.perr;
		if (st_reg.phase[PHASE_N-1]) begin
			perr_sum = st_reg.perr - PERR_W'(1);
		end else if (st_reg.phase != '0) begin
			perr_sum = st_reg.perr + PERR_W'(1);
		end
	end

	// frequency comparator: residual of the p count at the window end
	always_comb begin
		freq_equal = 1'b0;
		freq_low = 1'b0;
		freq_high = 1'b0;
		if (st_reg.pcount == p_factor_i) begin
			freq_equal = 1'b1;
		end else if (st_reg.pcount < p_factor_i) begin
			freq_low = 1'b1;
		end else begin
			freq_high = 1'b1;
		end
	end

	// phase comparator: a full period of error either way
	always_comb begin
		perr_full_pos = 1'b0;
		perr_full_neg = 1'b0;
		if (st_reg.perr >= period_lim) begin
			perr_full_pos = 1'b1;
		end else if (st_reg.perr <= -period_lim) begin
			perr_full_neg = 1'b1;
		end
	end

	// controller: acts on fq tick, frequency result, phase result
	always_comb begin
		sar_at_top = (st_reg.sar == '1);
		sar_at_bottom = (st_reg.sar == '0);
		step_up = 1'b0;
		step_down = 1'b0;
		sync_pulse = 1'b0;
		if (fq_tick) begin
			if (freq_low) begin
				step_up = !sar_at_top;
			end else if (freq_high) begin
				step_down = !sar_at_bottom;
			end else if (perr_full_pos) begin
				step_up = !sar_at_top;
			end else if (perr_full_neg) begin
				sync_pulse = 1'b1;
			end
		end
	end

	// saturating register step
	always_comb begin
		sar_stepped = st_reg.sar;
		if (step_up) begin
			sar_stepped = st_reg.sar + ACC_W'(1);
		end else if (step_down) begin
			sar_stepped = st_reg.sar - ACC_W'(1);
		end
	end

	// an edge on the window boundary opens the next window
	always_comb begin
		pcount_stepped = st_reg.pcount;
		if (fq_tick) begin
			pcount_stepped = out_rise ? DIV_W'(1) : '0;
		end else if (out_rise) begin
			pcount_stepped = st_reg.pcount + DIV_W'(1);
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.ref_sync = {st_reg.ref_sync[1:0], ref_i};
		st_next.acc = st_reg.acc + st_reg.sar;
		st_next.out_d = st_reg.acc[ACC_W-1];
		st_next.pcount = pcount_stepped;
		st_next.sar = sar_stepped;
		if (sync_pulse) begin
			st_next.acc = '0;
		end
		if (ref_rise) begin
			st_next.phase = phase_sampled;
			st_next.perr = perr_sum;
		end
		if (fq_tick) begin
			st_next.locked = freq_equal;
			if (!freq_equal || perr_full_pos || perr_full_neg) begin
				st_next.perr = '0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.sar <= ACC_W'(SAR_RST);
		end else begin
			st_reg <= st_next;
		end
	end

	assign clk_out_o = st_reg.acc[ACC_W-1];
	assign sar_o = st_reg.sar;
	assign phase_o = st_reg.phase;
	assign locked_o = st_reg.locked;
endmodule
`default_nettype wire

// *** tb/jbdpll_asserts.sv ***
// port checker for the pll top
// bound to every top instance
`timescale 1ns/1ps
`default_nettype none
module jbdpll_asserts
	import jbdpll_pkg::*;
#(parameter int ACC_W = 4, parameter int PHASE_N = 2) (
	input wire logic               clock_i,
	input wire logic               rst_n_i,
	input wire logic               ref_i,
	input wire logic               clk_out_o,
	input wire logic               locked_o,
	input wire logic [ACC_W-1:0]   sar_o,
	input wire logic [PHASE_N-1:0] phase_o
);
	logic [7:0] rh_reg;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// recent reference history
	always_ff @(posedge clock_i) rh_reg <= {rh_reg[6:0], ref_i};
	property p_rsar; disable iff (1'b0) !rst_n_i |=> sar_o == SAR_RST; endproperty
	a_rsar: assert property (p_rsar) else $error("sar reset");
	property p_rout; disable iff (1'b0)
		!rst_n_i |=> !clk_out_o && !locked_o && phase_o == 0; endproperty
	a_rout: assert property (p_rout) else $error("out reset");
	property p_step; $changed(sar_o) |->
		sar_o == $past(sar_o) + 1'b1 || sar_o == $past(sar_o) - 1'b1; endproperty
	a_step: assert property (p_step) else $error("sar jump");
	property p_hi; &sar_o |=> |sar_o; endproperty
	a_hi: assert property (p_hi) else $error("sar wrap up");
	property p_lo; !(|sar_o) |=> !(&sar_o); endproperty
	a_lo: assert property (p_lo) else $error("sar wrap down");
	property p_scause; $changed(sar_o) |-> |rh_reg[6:1]; endproperty
	a_scause: assert property (p_scause) else $error("sar idle change");
	property p_pcause; $changed(phase_o) |-> |rh_reg[6:1]; endproperty
	a_pcause: assert property (p_pcause) else $error("phase idle change");
	property p_lcause; $changed(locked_o) |-> |rh_reg[6:1]; endproperty
	a_lcause: assert property (p_lcause) else $error("lock idle change");
endmodule
bind jbdpll_top jbdpll_asserts #(.ACC_W(ACC_W), .PHASE_N(PHASE_N)) u_jbdpll_asserts (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .ref_i(ref_i), .clk_out_o(clk_out_o),
	.locked_o(locked_o), .sar_o(sar_o), .phase_o(phase_o));
`default_nettype wire

// *** tb/jbdpll_ref_src.sv ***
// reference source, high four clocks per period
// assumes the bench clock
`timescale 1ns/1ps
`default_nettype none
module jbdpll_ref_src (
	input  wire logic       clock_i,
	input  wire logic [7:0] per_i,
	output logic            ref_o
);
	logic [7:0] cnt_reg = 8'h00;
	logic       ref_reg = 1'b0;
	always @(posedge clock_i) begin
		cnt_reg <= (cnt_reg + 8'h01 >= per_i) ? 8'h00 : cnt_reg + 8'h01;
		ref_reg <= cnt_reg < 8'h04;
	end
	assign ref_o = ref_reg;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// bench for the pll top
// reference from the source model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import jbdpll_pkg::*;
	logic clock_i = 1'b0, rst_n_i = 1'b0;
	int n_lock = 0;
	logic [7:0] p_f = 8'h00, q_f = 8'h01, per = 8'h28;
	logic ref_w, clk_out, locked;
	logic [3:0] sar;
	logic [1:0] phase;
	int fail_count = 0, n_checks = 0;
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) if (locked === 1'b1) n_lock <= n_lock + 1;
	jbdpll_ref_src u_jbdpll_ref_src (.clock_i(clock_i), .per_i(per), .ref_o(ref_w));
	jbdpll_top u_jbdpll_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .ref_i(ref_w),
		.p_factor_i(p_f), .q_factor_i(q_f), .clk_out_o(clk_out), .sar_o(sar),
		.phase_o(phase), .locked_o(locked));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_reset;
		repeat (16) @(posedge clock_i);
		#1;
		check(sar, SAR_RST);
		check({clk_out, phase, locked}, 8'h00);
		@(posedge clock_i) rst_n_i <= 1'b1;
	endtask
	// target far above reach: climb and hold
	task automatic t_up;
		p_f <= 8'hC8;
		repeat (900) @(posedge clock_i);
		check(sar, 8'h0F);
		check(locked, 8'h00);
	endtask
	task automatic t_down;
		p_f <= 8'h00;
		repeat (900) @(posedge clock_i);
		check(sar < 4'h2, 8'h01);
	endtask
	// four edges per 16 clocks meets 32 per 128
	task automatic t_lock;
		int base;
		base = n_lock;
		per <= 8'h40;
		q_f <= 8'h02;
		p_f <= 8'h20;
		repeat (5120) @(posedge clock_i);
		check(sar >= 4'h3 && sar <= 4'h5, 8'h01);
		check(n_lock > base, 8'h01);
	endtask
	initial begin
		t_reset();
		t_up();
		t_down();
		t_lock();
		conclude();
	end
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
